/* File: rtl/gpc_params.svh */
/*
 Register addresses, field positions, reset values and codes for the
 general purpose checksum block. Assumes inclusion by bare name.
*/
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

`define GPC_ADDR_BIT_REVERSE   8'h96
`define GPC_ADDR_AUX_CONTROL   8'hA2
`define GPC_ADDR_DATA_PORT     8'hB6
`define GPC_ADDR_FLASH_MODE    8'hE5
`define GPC_ADDR_FLASH_CMD     8'hE6
`define GPC_ADDR_FLASH_ADR_H   8'hE7
`define GPC_ADDR_FLASH_ADR_L   8'hE8
`define GPC_ADDR_APP_BOUNDARY  8'hE9

`define GPC_SEL_LSB            4
`define GPC_SEL_MSB            5
`define GPC_AUX_KEEP_MASK      8'h31
`define GPC_SEL_SEED_LOW       2'h0
`define GPC_SEL_SEED_HIGH      2'h1
`define GPC_SEL_INPUT          2'h3

`define GPC_CRC_POLY           16'h1021
`define GPC_RESET_BYTE         8'h00
`define GPC_RESET_CRC          16'h0000

`define GPC_MODE_STANDBY       8'h00
`define GPC_MODE_BYTE_READ     8'h01
`define GPC_MODE_BYTE_PROG     8'h02
`define GPC_MODE_PAGE_ERASE    8'h03
`define GPC_MODE_PAGEP_WRITE   8'h04
`define GPC_MODE_PAGEP_READ    8'h05
`define GPC_MODE_AUTO_READ     8'h80
`define GPC_MODE_INC_READ      8'h81
`define GPC_MODE_INC_PROG      8'h82

`define GPC_CMD_FIRST          8'h46
`define GPC_CMD_SECOND         8'hB9
`define GPC_END_LOW_BITS       9'h1FF

`define GPC_FIFO_DEPTH         8
`endif

/* File: rtl/gpc_pkg.sv */
/*
 Types shared by the checksum block and its test bench.
 Assumes gpc_params.svh is compiled alongside.
*/
package gpc_pkg;

    typedef enum logic [2:0] {
        GPC_ST_IDLE  = 3'b001,
        GPC_ST_FETCH = 3'b010,
        GPC_ST_DONE  = 3'b100
    } gpc_state_type;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } gpc_flash_req_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpc_sfr_req_type;

endpackage

/* File: rtl/gpc_fifo.sv */
/*
 Byte FIFO in front of the checksum engine, flip-flop storage.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
    assign o_out_valid = (count_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_ptr_q];

    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/gpc_crc.sv */
/*
 General purpose checksum block: CCITT checksum with shared data port,
 flash auto-reload feed and bit-order reversal register.
 Assumes an SFR port synchronous to i_clk_sys with one-cycle strobes,
 and a flash port that answers each read strobe with an ack pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"

// What this block does
// - The checksum is 16 bits wide with generator polynomial 0x1021.
// - Input arrives as bytes, each folded into the running checksum.
// - Data port writes with selector 00 and 01 load the seed low and high bytes.
// - Data port reads with selector 00 and 01 return the result low and high bytes.
// - A selector 11 write feeds the checksum input; selector 10 writes and 10/11 reads are reserved.
// - The selector lives in bits 5:4 of the auxiliary control register and steers the data port.
// - The reversal register reads back the written byte bit-mirrored, so 0xA0 reads 0x05.
// - The checksum also takes bytes fetched from flash by the auto-reload engine.
// - The flash fetch starts at the address held in the flash address high and low registers.
// - The end address is the 7-bit boundary field above nine one bits.
// - The check starts only after 0x46 then 0xB9 are written to the flash command register.
// - Flash mode codes are 00,01,02,03,04,05,80,81,82; other values are reserved.
module gpc_crc #(
    parameter int FIFO_DEPTH = `GPC_FIFO_DEPTH
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    input  wire gpc_pkg::gpc_sfr_req_type   i_sfr,
    output logic [7:0]                      o_sfr_rdata,
    output gpc_pkg::gpc_flash_req_type      o_flash,
    input  wire logic                       i_flash_ack,
    input  wire logic [7:0]                 i_flash_data,
    output logic                            o_input_ready,
    output logic                            o_auto_busy
);
    gpc_pkg::gpc_state_type state_q;
    logic [7:0]  bit_reverse_data_q;
    logic [7:0]  aux_control_one_q;
    logic [7:0]  flash_mode_table_q;
    logic [7:0]  flash_address_high_q;
    logic [7:0]  flash_address_low_q;
    logic [6:0]  app_area_boundary_q;
    logic        cmd_armed_q;
    logic [15:0] crc_q;
    logic [15:0] fetch_addr_q;
    logic        fetch_pend_q;
    logic [1:0]  data_port_select;
    logic [15:0] end_addr;
    logic        wr_port;
    logic        rd_port;
    logic        seed_write;
    logic        cpu_byte;
    logic        start_auto;
    logic        fifo_in_valid;
    logic [7:0]  fifo_in_data;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `GPC_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] bit_mirror(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    function automatic logic mode_known(input logic [7:0] m);
        case (m)
            `GPC_MODE_STANDBY, `GPC_MODE_BYTE_READ, `GPC_MODE_BYTE_PROG, `GPC_MODE_PAGE_ERASE,
            `GPC_MODE_PAGEP_WRITE, `GPC_MODE_PAGEP_READ, `GPC_MODE_AUTO_READ,
            `GPC_MODE_INC_READ, `GPC_MODE_INC_PROG: mode_known = 1'b1;
            default: mode_known = 1'b0;
        endcase
    endfunction

    assign data_port_select = aux_control_one_q[`GPC_SEL_MSB:`GPC_SEL_LSB];
    assign end_addr   = {app_area_boundary_q, `GPC_END_LOW_BITS};
    assign wr_port    = i_sfr.wr && (i_sfr.addr == `GPC_ADDR_DATA_PORT);
    assign rd_port    = i_sfr.rd && (i_sfr.addr == `GPC_ADDR_DATA_PORT);
    assign seed_write = wr_port && !data_port_select[1];
    assign cpu_byte   = wr_port && (data_port_select == `GPC_SEL_INPUT);
    // Reserved mode codes never start the engine; only the auto read code does
    assign start_auto = i_sfr.wr && (i_sfr.addr == `GPC_ADDR_FLASH_CMD) && cmd_armed_q
                        && (i_sfr.wdata == `GPC_CMD_SECOND) && mode_known(flash_mode_table_q)
                        && (flash_mode_table_q == `GPC_MODE_AUTO_READ) && (state_q != gpc_pkg::GPC_ST_FETCH);

    // Flash bytes win the FIFO input; a CPU byte in that cycle is refused via o_input_ready
    assign fifo_in_valid  = i_flash_ack || cpu_byte;
    assign fifo_in_data   = i_flash_ack ? i_flash_data : i_sfr.wdata;
    assign o_input_ready  = fifo_in_ready && !fetch_pend_q;
    // Drain stalls on a seed write so the byte at the FIFO head is held and folded after the seed, not dropped
    assign fifo_out_ready = !seed_write;
    assign o_auto_busy    = (state_q == gpc_pkg::GPC_ST_FETCH);

    gpc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_in_valid (fifo_in_valid),
        .o_in_ready (fifo_in_ready),
        .i_in_data  (fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data (fifo_out_data)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bit_reverse_data_q   <= `GPC_RESET_BYTE;
            aux_control_one_q    <= `GPC_RESET_BYTE;
            flash_mode_table_q   <= `GPC_RESET_BYTE;
            flash_address_high_q <= `GPC_RESET_BYTE;
            flash_address_low_q  <= `GPC_RESET_BYTE;
            app_area_boundary_q  <= '0;
        end else if (i_sfr.wr) begin
            case (i_sfr.addr)
                `GPC_ADDR_BIT_REVERSE:  bit_reverse_data_q   <= i_sfr.wdata;
                `GPC_ADDR_AUX_CONTROL:  aux_control_one_q    <= i_sfr.wdata & `GPC_AUX_KEEP_MASK;
                `GPC_ADDR_FLASH_MODE:   flash_mode_table_q   <= i_sfr.wdata;
                `GPC_ADDR_FLASH_ADR_H:  flash_address_high_q <= i_sfr.wdata;
                `GPC_ADDR_FLASH_ADR_L:  flash_address_low_q  <= i_sfr.wdata;
                `GPC_ADDR_APP_BOUNDARY: app_area_boundary_q  <= i_sfr.wdata[6:0];
                default: ;
            endcase
        end
    end

    // Any command write other than the first key disarms the sequence
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmd_armed_q <= 1'b0;
        end else if (i_sfr.wr && (i_sfr.addr == `GPC_ADDR_FLASH_CMD)) begin
            cmd_armed_q <= (i_sfr.wdata == `GPC_CMD_FIRST);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            crc_q <= `GPC_RESET_CRC;
        end else if (seed_write) begin
            if (data_port_select == `GPC_SEL_SEED_LOW) begin
                crc_q[7:0] <= i_sfr.wdata;
            end else begin
                crc_q[15:8] <= i_sfr.wdata;
            end
        end else if (fifo_out_valid) begin
            crc_q <= crc_step(crc_q, fifo_out_data);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= `GPC_RESET_BYTE;
        end else if (i_sfr.rd) begin
            case (i_sfr.addr)
                `GPC_ADDR_BIT_REVERSE: o_sfr_rdata <= bit_mirror(bit_reverse_data_q);
                `GPC_ADDR_AUX_CONTROL: o_sfr_rdata <= aux_control_one_q;
                `GPC_ADDR_FLASH_MODE:  o_sfr_rdata <= flash_mode_table_q;
                `GPC_ADDR_FLASH_ADR_H: o_sfr_rdata <= flash_address_high_q;
                `GPC_ADDR_FLASH_ADR_L: o_sfr_rdata <= flash_address_low_q;
                `GPC_ADDR_APP_BOUNDARY: o_sfr_rdata <= {1'b0, app_area_boundary_q};
                `GPC_ADDR_DATA_PORT: begin
                    case (data_port_select)
                        `GPC_SEL_SEED_LOW:  o_sfr_rdata <= crc_q[7:0];
                        `GPC_SEL_SEED_HIGH: o_sfr_rdata <= crc_q[15:8];
                        default:            o_sfr_rdata <= `GPC_RESET_BYTE;
                    endcase
                end
                default: o_sfr_rdata <= `GPC_RESET_BYTE;
            endcase
        end
    end

    // One read outstanding at a time; a new strobe waits for FIFO room
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q      <= gpc_pkg::GPC_ST_IDLE;
            fetch_addr_q <= '0;
            fetch_pend_q <= 1'b0;
            o_flash      <= '0;
        end else begin
            o_flash.rd <= 1'b0;
            case (state_q)
                gpc_pkg::GPC_ST_IDLE, gpc_pkg::GPC_ST_DONE: begin
                    if (start_auto) begin
                        state_q      <= gpc_pkg::GPC_ST_FETCH;
                        fetch_addr_q <= {flash_address_high_q, flash_address_low_q};
                    end
                end
                gpc_pkg::GPC_ST_FETCH: begin
                    if (i_flash_ack) begin
                        fetch_pend_q <= 1'b0;
                        if (fetch_addr_q == end_addr) begin
                            state_q <= gpc_pkg::GPC_ST_DONE;
                        end else begin
                            fetch_addr_q <= fetch_addr_q + 16'h0001;
                        end
                    end else if (!fetch_pend_q && fifo_in_ready) begin
                        fetch_pend_q <= 1'b1;
                        o_flash.rd   <= 1'b1;
                        o_flash.addr <= fetch_addr_q;
                    end
                end
                default: state_q <= gpc_pkg::GPC_ST_IDLE;
            endcase
        end
    end

    a_seed_low_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        seed_write && data_port_select == `GPC_SEL_SEED_LOW |=> crc_q[7:0] == $past(i_sfr.wdata))
        else $error("seed low byte not loaded");

    a_crc_byte_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !seed_write && fifo_out_valid |=> crc_q == crc_step($past(crc_q), $past(fifo_out_data)))
        else $error("checksum step wrong");

    a_result_low_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_port && data_port_select == `GPC_SEL_SEED_LOW |=> o_sfr_rdata == $past(crc_q[7:0]))
        else $error("result low byte read wrong");

    a_result_high_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_port && data_port_select == `GPC_SEL_SEED_HIGH |=> o_sfr_rdata == $past(crc_q[15:8]))
        else $error("result high byte read wrong");

    a_reserved_port_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_port && data_port_select[1] |=> o_sfr_rdata == 8'h00)
        else $error("reserved data port read not zero");

    a_reverse_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == `GPC_ADDR_BIT_REVERSE ##1 !i_sfr.wr
        ##1 i_sfr.rd && i_sfr.addr == `GPC_ADDR_BIT_REVERSE |=> o_sfr_rdata == bit_mirror($past(i_sfr.wdata, 3)))
        else $error("bit reversal read back wrong");

    a_auto_start_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        start_auto |=> state_q == gpc_pkg::GPC_ST_FETCH
        && fetch_addr_q == {$past(flash_address_high_q), $past(flash_address_low_q)})
        else $error("auto reload did not start at loaded address");

    a_no_unkeyed_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q != gpc_pkg::GPC_ST_FETCH && !start_auto |=> state_q != gpc_pkg::GPC_ST_FETCH)
        else $error("auto reload started without key sequence");

    a_fetch_addr_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q == gpc_pkg::GPC_ST_FETCH && i_flash_ack && fetch_addr_q != end_addr
        |=> fetch_addr_q == $past(fetch_addr_q) + 16'h0001)
        else $error("fetch address did not step by one");

    a_fetch_end_stop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state_q == gpc_pkg::GPC_ST_FETCH && i_flash_ack && fetch_addr_q == end_addr
        |=> state_q == gpc_pkg::GPC_ST_DONE ##1 !o_flash.rd)
        else $error("fetch did not stop after end address");

    a_seed_high_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        seed_write && data_port_select == `GPC_SEL_SEED_HIGH |=> crc_q[15:8] == $past(i_sfr.wdata))
        else $error("seed high byte not loaded");

    // A reserved selector write must not disturb the running checksum
    a_reserved_write_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_port && data_port_select == 2'h2 && !fifo_out_valid |=> crc_q == $past(crc_q))
        else $error("reserved data port write changed checksum");

    a_selector_steer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == `GPC_ADDR_AUX_CONTROL
        |=> data_port_select == $past(i_sfr.wdata[`GPC_SEL_MSB:`GPC_SEL_LSB]))
        else $error("selector not taken from aux control bits 5 and 4");

    a_aux_read_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.rd && i_sfr.addr == `GPC_ADDR_AUX_CONTROL |=> (o_sfr_rdata & ~`GPC_AUX_KEEP_MASK) == 8'h00)
        else $error("unused aux control bits read back set");

    a_mode_store: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == `GPC_ADDR_FLASH_MODE |=> flash_mode_table_q == $past(i_sfr.wdata))
        else $error("flash mode code not stored");

    // Empty queue: a byte accepted now must be the next one the engine folds
    a_cpu_byte_queue: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cpu_byte && o_input_ready && !i_flash_ack && !fifo_out_valid
        |=> fifo_out_valid && fifo_out_data == $past(i_sfr.wdata))
        else $error("written byte did not reach the checksum input");

    a_flash_byte_queue: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_flash_ack && !fifo_out_valid |=> fifo_out_valid && fifo_out_data == $past(i_flash_data))
        else $error("flash byte did not reach the checksum input");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/*
 Self-checking bench for the checksum block: register access, seed and
 result, byte feed, reserved selector, mode codes, key sequence, auto-reload.
 Assumes gpc_pkg and gpc_params.svh are compiled first; the bench answers flash reads.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module tb_top;
    logic                       i_clk_sys;
    logic                       i_rst_n;
    gpc_pkg::gpc_sfr_req_type   sfr;
    logic [7:0]                 rdata;
    gpc_pkg::gpc_flash_req_type flash;
    logic                       flash_ack;
    logic [7:0]                 flash_data;
    logic                       in_ready;
    logic                       busy;
    int                         n_mismatch;
    int                         num_checks;
    int                         n_reads;
    int                         pend;
    logic                       rd_s;
    logic [15:0]                a_s;
    logic [15:0]                ack_addr;
    logic [15:0]                exp_addr;
    logic [15:0]                crc;
    logic [15:0]                res;
    logic [7:0]                 codes [9];

    gpc_crc #(.FIFO_DEPTH(`GPC_FIFO_DEPTH)) u_gpc_crc (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (i_rst_n),
        .i_sfr        (sfr),
        .o_sfr_rdata  (rdata),
        .o_flash      (flash),
        .i_flash_ack  (flash_ack),
        .i_flash_data (flash_data),
        .o_input_ready(in_ready),
        .o_auto_busy  (busy)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // MSB first, unreflected, no final inversion
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ b[i];
            c  = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ `GPC_CRC_POLY;
            end
        end
        return c;
    endfunction

    function automatic logic [7:0] fl_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction

    task automatic results;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_up(input string name);
        n_mismatch++;
        // A spent wait only counts; the run still ends in the one verdict
        $display("MISMATCH %s expected done seen timeout", name);
    endtask

    // One idle cycle after each strobe so no signal is driven twice in a step
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr.addr  = a;
        sfr.wdata = d;
        sfr.wr    = 1'b1;
        @(posedge i_clk_sys);
        #1;
        sfr.wr = 1'b0;
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        sfr.addr = a;
        sfr.rd   = 1'b1;
        @(posedge i_clk_sys);
        #1;
        sfr.rd = 1'b0;
        check(name, {8'h00, rdata}, {8'h00, exp});
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic set_seed(input logic [15:0] s);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h00);
        sfr_wr(`GPC_ADDR_DATA_PORT, s[7:0]);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h10);
        sfr_wr(`GPC_ADDR_DATA_PORT, s[15:8]);
    endtask

    task automatic feed(input logic [7:0] b);
        for (int i = 0; i < 50 && in_ready !== 1'b1; i++) begin
            @(posedge i_clk_sys);
            #1;
        end
        if (in_ready !== 1'b1) begin
            give_up("input_ready");
        end
        sfr_wr(`GPC_ADDR_DATA_PORT, b);
    endtask

    task automatic result_chk(input logic [15:0] exp);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h00);
        rd_chk(`GPC_ADDR_DATA_PORT, exp[7:0], "result_low_byte");
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h10);
        rd_chk(`GPC_ADDR_DATA_PORT, exp[15:8], "result_high_byte");
    endtask

    // Flash side: answers promptly and slowly in turn; a released data line keeps toggling
    always @(posedge i_clk_sys) begin
        rd_s = flash.rd;
        a_s  = flash.addr;
        #1;
        if (pend == 1) begin
            flash_ack  = 1'b1;
            flash_data = fl_byte(ack_addr);
        end else begin
            flash_ack  = 1'b0;
            flash_data = ~flash_data;
        end
        if (pend > 0) begin
            pend--;
        end
        if (rd_s === 1'b1) begin
            check("flash_addr", a_s, exp_addr);
            exp_addr = exp_addr + 16'h0001;
            n_reads++;
            ack_addr = a_s;
            pend     = n_reads[0] ? 1 : 4;
        end
    end

    initial begin
        sfr        = '0;
        i_rst_n    = 1'b0;
        flash_ack  = 1'b0;
        flash_data = 8'h00;
        n_mismatch = 0;
        num_checks = 0;
        n_reads    = 0;
        pend       = 0;
        exp_addr   = 16'h0000;
        codes      = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80, 8'h81, 8'h82};
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        check("input_ready", {15'h0000, in_ready}, 16'h0001);
        rd_chk(`GPC_ADDR_BIT_REVERSE, 8'h00, "bit_reverse_data");
        rd_chk(`GPC_ADDR_AUX_CONTROL, 8'h00, "aux_control_one");
        rd_chk(`GPC_ADDR_DATA_PORT, 8'h00, "result_low_byte");
        rd_chk(`GPC_ADDR_FLASH_MODE, 8'h00, "flash_mode_table");
        rd_chk(8'h10, 8'h00, "unmapped");
        sfr_wr(`GPC_ADDR_BIT_REVERSE, 8'hA0);
        rd_chk(`GPC_ADDR_BIT_REVERSE, 8'h05, "bit_reverse_data");
        sfr_wr(`GPC_ADDR_BIT_REVERSE, 8'h01);
        rd_chk(`GPC_ADDR_BIT_REVERSE, 8'h80, "bit_reverse_data");
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'hFF);
        rd_chk(`GPC_ADDR_AUX_CONTROL, 8'h31, "aux_control_one");
        set_seed(16'h1234);
        result_chk(16'h1234);
        // Known answer pins the bench's own model before it judges the design
        set_seed(16'hFFFF);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h30);
        crc = 16'hFFFF;
        for (int i = 1; i <= 9; i++) begin
            feed(8'h30 + i[7:0]);
            crc = crc_step(crc, 8'h30 + i[7:0]);
        end
        check("model", crc, 16'h29B1);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h20);
        sfr_wr(`GPC_ADDR_DATA_PORT, 8'hC3);
        rd_chk(`GPC_ADDR_DATA_PORT, 8'h00, "reserved_read");
        result_chk(crc);
        foreach (codes[i]) begin
            sfr_wr(`GPC_ADDR_FLASH_MODE, codes[i]);
            rd_chk(`GPC_ADDR_FLASH_MODE, codes[i], "flash_mode_table");
        end
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h30);
        rd_chk(`GPC_ADDR_DATA_PORT, 8'h00, "reserved_read");
        sfr_wr(`GPC_ADDR_FLASH_MODE, `GPC_MODE_AUTO_READ);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_FIRST);
        sfr_wr(`GPC_ADDR_FLASH_CMD, 8'h00);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_SECOND);
        sfr_wr(`GPC_ADDR_FLASH_MODE, `GPC_MODE_BYTE_READ);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_FIRST);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_SECOND);
        repeat (10) @(posedge i_clk_sys);
        #1;
        check("broken_key_reads", n_reads[15:0], 16'h0000);
        set_seed(16'hFFFF);
        sfr_wr(`GPC_ADDR_AUX_CONTROL, 8'h30);
        sfr_wr(`GPC_ADDR_APP_BOUNDARY, 8'h05);
        sfr_wr(`GPC_ADDR_FLASH_ADR_H, 8'h0B);
        sfr_wr(`GPC_ADDR_FLASH_ADR_L, 8'hFC);
        exp_addr = 16'h0BFC;
        sfr_wr(`GPC_ADDR_FLASH_MODE, `GPC_MODE_AUTO_READ);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_FIRST);
        sfr_wr(`GPC_ADDR_FLASH_CMD, `GPC_CMD_SECOND);
        check("auto_busy", {15'h0000, busy}, 16'h0001);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
            @(posedge i_clk_sys);
            #1;
        end
        if (busy !== 1'b0) begin
            give_up("auto_busy");
        end
        repeat (10) @(posedge i_clk_sys);
        #1;
        // End address is {boundary 05, nine ones}, so exactly four bytes
        check("auto_reads", n_reads[15:0], 16'h0004);
        crc = 16'hFFFF;
        for (int a = 16'h0BFC; a <= 16'h0BFF; a++) begin
            crc = crc_step(crc, fl_byte(a[15:0]));
        end
        result_chk(crc);
        // Reset after the finished run must bring back the idle values
        i_rst_n = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        check("auto_busy", {15'h0000, busy}, 16'h0000);
        rd_chk(`GPC_ADDR_FLASH_MODE, 8'h00, "flash_mode_table");
        result_chk(16'h0000);
        results();
    end
endmodule
`default_nettype wire
